// ==== logic/sras_host.sv ====
`timescale 1ns/1ns
module sras_host #(
	parameter int HALF_CYC = sras_pkg::SCL_HALF_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Two-wire bus
	sras_if.host bus,
	// Command port
	input wire logic cmd_valid,
	input wire sras_pkg::sras_cmd_type cmd,
	input wire logic [6:0] cmd_addr,
	input wire logic [7:0] cmd_ptr,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack
);
	typedef enum logic [2:0] {
		H_IDLE,
		H_START,
		H_BYTE,
		H_STOP,
		H_DONE
	} sras_host_state_type;

	typedef struct packed {
		sras_host_state_type st;
		logic [15:0] tick;
		logic [1:0] phase;
		logic [3:0] bitn;
		logic [1:0] bytei;
		logic [7:0] tx;
		logic [7:0] rx;
		sras_pkg::sras_cmd_type op;
		logic [6:0] addr;
		logic [7:0] ptr;
		logic [7:0] data;
		logic scl;
		logic sda;
		logic nack;
		logic rsp;
		logic rdy;
	} sras_host_s_type;

	sras_host_s_type h_r;
	sras_host_s_type h_nxt;
	logic sda_s;
	logic [1:0] nbytes;
	logic tick_end;
	logic host_rx;

	// ----------------------------------------------------------------
	// Data line synchroniser
	// ----------------------------------------------------------------
	sras_sync u_sync_sda (.mclk(mclk), .nrst(nrst), .din(bus.sda), .dout(sda_s));

	assign tick_end = h_r.tick == 16'(HALF_CYC - 1);
	// Write: addr ptr data; setptr: addr ptr; read: addr(read) data
	assign nbytes = (h_r.op == sras_pkg::SRAS_CMD_WRITE) ? 2'd2 : 2'd1;
	// Byte driven by the device: the data byte of a read
	assign host_rx = h_r.op == sras_pkg::SRAS_CMD_READ && h_r.bytei != 2'd0;

	// Master sequencer: four phases per bit
	always_comb begin
		h_nxt = h_r;
		h_nxt.rsp = 1'b0;
		h_nxt.tick = tick_end ? 16'h0000 : h_r.tick + 16'h0001;
		case (h_r.st)
			H_IDLE: begin
				h_nxt.tick = 16'h0000;
				h_nxt.rdy = 1'b1;
				if (cmd_valid && h_r.rdy) begin
					h_nxt.rdy = 1'b0;
					h_nxt.op = cmd;
					h_nxt.addr = cmd_addr;
					h_nxt.ptr = cmd_ptr;
					h_nxt.data = cmd_data;
					h_nxt.nack = 1'b0;
					h_nxt.st = H_START;
				end
			end
			H_START: begin
				if (tick_end) begin
					h_nxt.sda = 1'b0;
					h_nxt.st = H_BYTE;
					h_nxt.bytei = 2'd0;
					h_nxt.bitn = 4'h0;
					h_nxt.phase = 2'd0;
					h_nxt.tx = {h_r.addr, h_r.op == sras_pkg::SRAS_CMD_READ};
				end
			end
			H_BYTE: begin
				if (tick_end) begin
					h_nxt.phase = h_r.phase + 2'd1;
					case (h_r.phase)
						2'd0: begin
							h_nxt.scl = 1'b0;
						end
						2'd1: begin
							// Data changes only while clock low
							if (h_r.bitn == 4'h8) begin
								// Release for device ack; nack the single read byte
								h_nxt.sda = 1'b1;
							end else if (host_rx) begin
								h_nxt.sda = 1'b1;
							end else begin
								h_nxt.sda = h_r.tx[7];
								h_nxt.tx = {h_r.tx[6:0], 1'b0};
							end
						end
						2'd2: begin
							h_nxt.scl = 1'b1;
						end
						default: begin
							h_nxt.bitn = h_r.bitn + 4'h1;
							if (h_r.bitn < 4'h8) begin
								h_nxt.rx = {h_r.rx[6:0], sda_s};
							end else begin
								h_nxt.bitn = 4'h0;
								h_nxt.bytei = h_r.bytei + 2'd1;
								h_nxt.tx = (h_r.bytei == 2'd0) ? h_r.ptr : h_r.data;
								if (h_r.bytei == nbytes || (sda_s && !host_rx)) begin
									h_nxt.nack = sda_s && !host_rx;
									h_nxt.st = H_STOP;
								end
							end
						end
					endcase
				end
			end
			H_STOP: begin
				if (tick_end) begin
					h_nxt.phase = h_r.phase + 2'd1;
					case (h_r.phase)
						2'd0: begin
							h_nxt.scl = 1'b0;
						end
						2'd1: begin
							h_nxt.sda = 1'b0;
						end
						2'd2: begin
							h_nxt.scl = 1'b1;
						end
						default: begin
							h_nxt.sda = 1'b1;
							h_nxt.st = H_DONE;
						end
					endcase
				end
			end
			H_DONE: begin
				if (tick_end) begin
					h_nxt.rsp = 1'b1;
					h_nxt.st = H_IDLE;
				end
			end
			default: begin
				h_nxt.st = H_IDLE;
			end
		endcase
	end

	// State register, bus idles high
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			h_r <= '0;
			h_r.st <= H_IDLE;
			h_r.scl <= 1'b1;
			h_r.sda <= 1'b1;
		end else begin
			h_r <= h_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus.scl_out = h_r.scl;
	assign bus.scl_oe = !h_r.scl;
	assign bus.sda_host_out = h_r.sda;
	assign bus.sda_host_oe = !h_r.sda;
	assign cmd_ready = h_r.rdy;
	assign rsp_valid = h_r.rsp;
	assign rsp_data = h_r.rx;
	assign rsp_nack = h_r.nack;
endmodule

// ==== include/sras_pkg.sv ====
package sras_pkg;
	// ----------------------------------------------------------------
	// Bus addressing
	// ----------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR_BASE = 7'h4C;
	localparam logic [7:0] REG_BLOCKED = 8'h0F;
	localparam int REG_COUNT = 16;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int MCLK_HZ = 50000000;
	localparam int SCL_HALF_NS = 2500;
	localparam int SCL_HALF_CYC = SCL_HALF_NS / (1000000000 / MCLK_HZ);
	localparam int BIT_LAST = 7;
	localparam int ACK_BIT = 8;
	// ----------------------------------------------------------------
	// Host commands
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SRAS_CMD_WRITE,
		SRAS_CMD_READ,
		SRAS_CMD_SETPTR
	} sras_cmd_type;
endpackage

// ==== include/sras_if.sv ====
`timescale 1ns/1ns
interface sras_if;
	logic scl_out;
	logic scl_oe;
	logic sda_dev_out;
	logic sda_dev_oe;
	logic sda_host_out;
	logic sda_host_oe;
	logic scl;
	logic sda;

	// Open-drain wired-and with pull-ups
	assign scl = scl_oe ? scl_out : 1'b1;
	assign sda = (sda_dev_oe && !sda_dev_out) || (sda_host_oe && !sda_host_out) ? 1'b0 : 1'b1;

	modport dev (
		input scl,
		input sda,
		output sda_dev_out,
		output sda_dev_oe
	);
	modport host (
		input scl,
		input sda,
		output scl_out,
		output scl_oe,
		output sda_host_out,
		output sda_host_oe
	);
endinterface

// ==== logic/sras_sync.sv ====
`timescale 1ns/1ns
module sras_sync (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Asynchronous level in, synchronised level out
	input wire logic din,
	output logic dout
);
	logic meta_r;

	// Two flops, reset to the idle-high bus level
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= 1'b1;
			dout <= 1'b1;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule

// ==== logic/sras_dev.sv ====
`timescale 1ns/1ns
module sras_dev #(
	parameter int NREGS = sras_pkg::REG_COUNT
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Strap and power pins
	input wire logic [1:0] slave_addr_select_pins,
	input wire logic low_power_input_n,
	// Two-wire bus
	sras_if.dev bus,
	// Register contents to the digitizer core
	output logic [8*NREGS-1:0] reg_image,
	output logic wr_strobe,
	output logic [7:0] wr_index
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_PTR,
		ST_WDATA,
		ST_RDATA,
		ST_IGNORE
	} sras_dev_state_type;

	typedef struct packed {
		sras_dev_state_type st;
		logic scl_d;
		logic sda_d;
		logic [3:0] bitn;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic rd_dir;
		logic ack_slot;
		logic acked;
		logic sda_out;
		logic sda_oe;
		logic [6:0] addr;
		logic [1:0] sel_m;
		logic [1:0] sel_s;
		logic strobe;
		logic [7:0] windex;
		logic [NREGS-1:0][7:0] regs;
	} sras_dev_s_type;

	sras_dev_s_type s_r;
	sras_dev_s_type s_nxt;
	logic scl_s;
	logic sda_s;
	logic lp_n_s;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	sras_sync u_sync_scl (.mclk(mclk), .nrst(nrst), .din(bus.scl), .dout(scl_s));
	sras_sync u_sync_sda (.mclk(mclk), .nrst(nrst), .din(bus.sda), .dout(sda_s));
	sras_sync u_sync_lp (.mclk(mclk), .nrst(nrst), .din(low_power_input_n), .dout(lp_n_s));

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [7:0] rd_byte;
	logic [7:0] rx_byte;

	// ----------------------------------------------------------------
	// Line events
	// ----------------------------------------------------------------
	assign scl_rise = scl_s && !s_r.scl_d;
	assign scl_fall = !scl_s && s_r.scl_d;
	assign start_seen = scl_s && s_r.scl_d && s_r.sda_d && !sda_s;
	assign stop_seen = scl_s && s_r.scl_d && !s_r.sda_d && sda_s;
	assign rx_byte = {s_r.shift[6:0], sda_s};
	assign rd_byte = (s_r.ptr < 8'(NREGS)) ? s_r.regs[s_r.ptr[3:0]] : 8'h00;

	// Next-state logic for the whole port
	always_comb begin
		s_nxt = s_r;
		s_nxt.scl_d = scl_s;
		s_nxt.sda_d = sda_s;
		s_nxt.strobe = 1'b0;
		// Strap pins pass two flops before the address is formed
		s_nxt.sel_m = slave_addr_select_pins;
		s_nxt.sel_s = s_r.sel_m;
		s_nxt.addr = sras_pkg::SLAVE_ADDR_BASE | {5'h00, s_r.sel_s};
		if (!lp_n_s) begin
			// Registers held, line released
			s_nxt.sda_oe = 1'b0;
			s_nxt.st = ST_IDLE;
		end else if (start_seen) begin
			s_nxt.st = ST_ADDR;
			s_nxt.bitn = 4'h0;
			s_nxt.ack_slot = 1'b0;
			s_nxt.sda_oe = 1'b0;
		end else if (stop_seen) begin
			s_nxt.st = ST_IDLE;
			s_nxt.sda_oe = 1'b0;
		end else if (scl_rise && s_r.st != ST_IDLE && s_r.st != ST_IGNORE) begin
			if (!s_r.ack_slot) begin
				// Read bytes shift on the falling edge instead
				if (s_r.st != ST_RDATA) begin
					s_nxt.shift = rx_byte;
				end
				s_nxt.bitn = s_r.bitn + 4'h1;
			end else if (s_r.st == ST_RDATA && sda_s) begin
				s_nxt.st = ST_IGNORE;
			end
		end else if (scl_fall && s_r.st != ST_IDLE && s_r.st != ST_IGNORE) begin
			// Drive only after clock falls
			s_nxt.sda_oe = 1'b0;
			if (s_r.ack_slot) begin
				s_nxt.ack_slot = 1'b0;
				s_nxt.bitn = 4'h0;
				if (!s_r.acked) begin
					s_nxt.st = ST_IGNORE;
				end else if (s_r.st == ST_RDATA) begin
					s_nxt.sda_out = rd_byte[sras_pkg::BIT_LAST];
					s_nxt.sda_oe = !rd_byte[sras_pkg::BIT_LAST];
					s_nxt.shift = {rd_byte[6:0], 1'b0};
					s_nxt.ptr = s_r.ptr + 8'h01;
				end
			end else if (s_r.bitn == 4'(sras_pkg::ACK_BIT)) begin
				s_nxt.ack_slot = 1'b1;
				s_nxt.acked = 1'b0;
				case (s_r.st)
					ST_ADDR: begin
						if (s_r.shift[7:1] == s_r.addr && !(s_r.shift[0] && s_r.ptr == sras_pkg::REG_BLOCKED)) begin
							s_nxt.acked = 1'b1;
							s_nxt.rd_dir = s_r.shift[0];
							s_nxt.st = s_r.shift[0] ? ST_RDATA : ST_PTR;
						end
					end
					ST_PTR: begin
						s_nxt.ptr = s_r.shift;
						s_nxt.acked = s_r.shift != sras_pkg::REG_BLOCKED;
						s_nxt.st = ST_WDATA;
					end
					ST_WDATA: begin
						if (s_r.ptr != sras_pkg::REG_BLOCKED) begin
							s_nxt.acked = 1'b1;
							if (s_r.ptr < 8'(NREGS)) begin
								s_nxt.regs[s_r.ptr[3:0]] = s_r.shift;
							end
							s_nxt.strobe = 1'b1;
							s_nxt.windex = s_r.ptr;
							s_nxt.ptr = s_r.ptr + 8'h01;
						end
					end
					ST_RDATA: begin
						s_nxt.acked = 1'b1;
					end
					default: begin
						s_nxt.acked = 1'b0;
					end
				endcase
				// Master samples ack, device drives low only
				s_nxt.sda_out = 1'b0;
				s_nxt.sda_oe = s_nxt.acked && s_r.st != ST_RDATA;
				if (s_r.st == ST_RDATA) begin
					s_nxt.acked = 1'b1;
				end
			end else if (s_r.st == ST_RDATA) begin
				s_nxt.sda_out = s_r.shift[7];
				s_nxt.sda_oe = !s_r.shift[7];
				s_nxt.shift = {s_r.shift[6:0], 1'b0};
			end
		end
	end

	// State register; slave never drives the clock
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
			s_r.scl_d <= 1'b1;
			s_r.sda_d <= 1'b1;
			s_r.sda_out <= 1'b1;
			s_r.addr <= sras_pkg::SLAVE_ADDR_BASE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus.sda_dev_out = s_r.sda_out;
	assign bus.sda_dev_oe = s_r.sda_oe;
	assign reg_image = s_r.regs;
	assign wr_strobe = s_r.strobe;
	assign wr_index = s_r.windex;
endmodule

// ==== verification/sras_monitor.sv ====
`timescale 1ns/1ns
module sras_monitor (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Resolved lines and device drive
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_oe
);
	logic scl_q;
	logic sda_q;
	logic busy;
	logic first;
	logic [3:0] cnt;
	logic [7:0] sh;
	wire start = scl_q && scl && sda_q && !sda;
	wire stop = scl_q && scl && !sda_q && sda;
	wire scl_up = !scl_q && scl;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// Line history, bit position and first-byte capture
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			busy <= 1'b0;
			first <= 1'b0;
			cnt <= 4'h0;
			sh <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start) begin
				busy <= 1'b1;
				first <= 1'b1;
				cnt <= 4'h0;
			end else if (stop) begin
				busy <= 1'b0;
			end else if (scl_up) begin
				cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
				if (cnt == 4'h8)
					first <= 1'b0;
				if (first && cnt < 4'h8)
					sh <= {sh[6:0], sda};
			end
		end
	end

	// Ack held across one whole clock pulse
	sequence ack_pulse;
		##[1:40] $rose(scl) ##[1:40] $fell(scl);
	endsequence
	sequence idle_pair;
		(scl && sda) [*2];
	endsequence

	a_dev_change_low: assert property ($changed(sda_dev_oe) |-> !scl)
		else $error("device changed data while clock high");
	a_no_dev_start: assert property (scl && $fell(sda) |-> !sda_dev_oe)
		else $error("device pulled data low while clock high");
	a_stop_idle: assert property (stop |=> idle_pair)
		else $error("lines not idle after stop");
	a_addr_quiet: assert property (scl_up && first && cnt < 4'h8 |-> !sda_dev_oe)
		else $error("device drove during address byte");
	a_ack_slot: assert property ($rose(sda_dev_oe) && first |-> cnt == 4'h8)
		else $error("address ack outside ninth bit");
	a_ack_held: assert property ($rose(sda_dev_oe) && first |-> sda_dev_oe throughout ack_pulse)
		else $error("address ack not held over ninth pulse");
	a_foreign_nack: assert property (scl_up && first && cnt == 4'h8 && sh[7:3] != 5'h13 |-> sda)
		else $error("device acked a foreign address");
	a_idle_quiet: assert property (!busy |-> !sda_dev_oe)
		else $error("device drove data outside a transfer");
endmodule

// ==== verification/serial_register_access_slave_tb.sv ====
`timescale 1ns/1ns
module serial_register_access_slave_tb;
	localparam logic [6:0] ADDR = 7'h4F;
	logic mclk;
	logic nrst;
	logic cmd_valid;
	sras_pkg::sras_cmd_type cmd;
	logic [6:0] cmd_addr;
	logic [7:0] cmd_ptr;
	logic [7:0] cmd_data;
	logic cmd_ready;
	logic rsp_valid;
	logic [7:0] rsp_data;
	logic rsp_nack;
	logic [1:0] sel;
	logic lp_n;
	logic [127:0] reg_image;
	logic wr_strobe;
	logic [7:0] wr_index;
	int errors;
	int checked;
	int strobes;

	sras_if sras_if_i();
	sras_host #(.HALF_CYC(8)) sras_host_i (.mclk(mclk), .nrst(nrst), .bus(sras_if_i),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr), .cmd_ptr(cmd_ptr),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_nack(rsp_nack));
	sras_dev sras_dev_i (.mclk(mclk), .nrst(nrst), .slave_addr_select_pins(sel),
		.low_power_input_n(lp_n), .bus(sras_if_i), .reg_image(reg_image),
		.wr_strobe(wr_strobe), .wr_index(wr_index));
	sras_monitor sras_monitor_i (.mclk(mclk), .nrst(nrst), .scl(sras_if_i.scl),
		.sda(sras_if_i.sda), .sda_dev_oe(sras_if_i.sda_dev_oe));

	// Clock
	always #10 mclk = ~mclk;

	// Count stored-byte strobes
	always @(posedge mclk) begin
		if (wr_strobe === 1'b1)
			strobes++;
	end

	task automatic conclude();
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One host command, waits for its response pulse
	task automatic run(sras_pkg::sras_cmd_type c, logic [6:0] a, logic [7:0] p, logic [7:0] d);
		int n;
		@(posedge mclk);
		while (cmd_ready !== 1'b1)
			@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd <= c;
		cmd_addr <= a;
		cmd_ptr <= p;
		cmd_data <= d;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 3000) begin
			@(posedge mclk);
			n++;
		end
		check("response", {7'h00, rsp_valid}, 8'h01);
	endtask

	task automatic s_address();
		for (int k = 0; k < 4; k++) begin
			sel <= 2'(k);
			run(sras_pkg::SRAS_CMD_WRITE, 7'(7'h4C + k), 8'h01, 8'(8'h30 + k));
			check("ack", {7'h00, rsp_nack}, 8'h00);
			check("reg1", reg_image[15:8], 8'(8'h30 + k));
			check("index", wr_index, 8'h01);
			run(sras_pkg::SRAS_CMD_WRITE, 7'(7'h4C + (k + 1) % 4), 8'h01, 8'hEE);
			check("nack", {7'h00, rsp_nack}, 8'h01);
			check("reg1 kept", reg_image[15:8], 8'(8'h30 + k));
		end
		run(sras_pkg::SRAS_CMD_WRITE, 7'h2A, 8'h01, 8'h55);
		check("foreign nack", {7'h00, rsp_nack}, 8'h01);
		check("reg1 foreign", reg_image[15:8], 8'h33);
	endtask

	task automatic s_increment();
		run(sras_pkg::SRAS_CMD_WRITE, ADDR, 8'h04, 8'hB1);
		check("reg4", reg_image[39:32], 8'hB1);
		run(sras_pkg::SRAS_CMD_WRITE, ADDR, 8'h05, 8'h6D);
		run(sras_pkg::SRAS_CMD_WRITE, ADDR, 8'h03, 8'h96);
		run(sras_pkg::SRAS_CMD_READ, ADDR, 8'h00, 8'h00);
		check("read after write", rsp_data, 8'hB1);
		run(sras_pkg::SRAS_CMD_READ, ADDR, 8'h00, 8'h00);
		check("read after read", rsp_data, 8'h6D);
		check("strobes", 8'(strobes), 8'h07);
	endtask

	task automatic s_blocked();
		run(sras_pkg::SRAS_CMD_WRITE, ADDR, 8'h0F, 8'h77);
		check("write nack", {7'h00, rsp_nack}, 8'h01);
		check("reg15", reg_image[127:120], 8'h00);
		run(sras_pkg::SRAS_CMD_SETPTR, ADDR, 8'h0F, 8'h00);
		check("setptr nack", {7'h00, rsp_nack}, 8'h01);
		run(sras_pkg::SRAS_CMD_READ, ADDR, 8'h00, 8'h00);
		check("read nack", {7'h00, rsp_nack}, 8'h01);
		run(sras_pkg::SRAS_CMD_SETPTR, ADDR, 8'h03, 8'h00);
		run(sras_pkg::SRAS_CMD_READ, ADDR, 8'h00, 8'h00);
		check("pointed read", rsp_data, 8'h96);
	endtask

	task automatic s_power();
		lp_n <= 1'b0;
		run(sras_pkg::SRAS_CMD_WRITE, ADDR, 8'h04, 8'h11);
		check("asleep nack", {7'h00, rsp_nack}, 8'h01);
		check("reg4 kept", reg_image[39:32], 8'hB1);
		check("asleep strobes", 8'(strobes), 8'h07);
		lp_n <= 1'b1;
		run(sras_pkg::SRAS_CMD_SETPTR, ADDR, 8'h05, 8'h00);
		run(sras_pkg::SRAS_CMD_READ, ADDR, 8'h00, 8'h00);
		check("awake read", rsp_data, 8'h6D);
	endtask

	// Reset and main sequence
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		cmd_valid = 1'b0;
		cmd = sras_pkg::SRAS_CMD_WRITE;
		cmd_addr = 7'h00;
		cmd_ptr = 8'h00;
		cmd_data = 8'h00;
		sel = 2'h0;
		lp_n = 1'b1;
		errors = 0;
		checked = 0;
		strobes = 0;
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		s_address();
		s_increment();
		s_blocked();
		s_power();
		conclude();
	end

	// Watchdog
	initial begin
		#1200000;
		errors++;
		conclude();
	end
endmodule
